// >>> pkg/icu_pkg.sv
// Shared constants, register map and types of the interrupt control unit
package icu_pkg;

    // Source groups and level fields
    localparam int NUM_SRC = 23;
    localparam int LVL_W = 3;
    localparam int IDX_W = 5;
    localparam int VEC_W = 16;
    localparam logic [LVL_W-1:0] LEVEL_DISABLED = 3'h7;
    localparam logic [LVL_W-1:0] LEVEL_RESET = 3'h7;
    localparam logic [LVL_W-1:0] MASK_RESET = 3'h7;
    localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;
    localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;

    // Wishbone register byte addresses
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADR_MASK = 8'h00;
    localparam logic [ADR_W-1:0] ADR_VECTOR = 8'h04;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;
    localparam logic [ADR_W-1:0] ADR_CLEAR = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_ENABLE = 8'h10;
    localparam logic [ADR_W-1:0] ADR_CTRL_BASE = 8'h40;
    localparam logic [ADR_W-1:0] ADR_CTRL_LAST = 8'h98;
    localparam int ADR_WORD_SHIFT = 2;

    // Per-source control word fields
    localparam int CTRL_LVL_LSB = 0;
    localparam int CTRL_PEND_BIT = 4;

    // Event status bits
    localparam int EV_W = 2;
    localparam int EV_ACCEPT = 0;
    localparam int EV_EDGE = 1;
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Edge-detected groups: timer output 5, both serial pairs, converter, debugger
    localparam logic [NUM_SRC-1:0] EDGE_SRC = 23'h13E040;

    // Vector table entry per source, in fixed hardware order
    localparam logic [VEC_W-1:0] VECTOR_TABLE [NUM_SRC] = '{
        16'h0094, 16'h0098, 16'h009C, 16'h00A0,
        16'h00A8, 16'h00AC, 16'h00B0, 16'h00B4,
        16'h00B8, 16'h00BC, 16'h00C0, 16'h00C4,
        16'h00C8, 16'h00CC, 16'h00D0, 16'h00D4,
        16'h00D8, 16'h00DC, 16'h00E8, 16'h00EC,
        16'h00F0, 16'h010C, 16'h0110
    };

    typedef enum logic [0:0] {
        ST_RESOLVE = 1'b0,
        ST_REQUEST = 1'b1
    } res_state_t;

    function automatic logic [VEC_W-1:0] vector_entry(input logic [IDX_W-1:0] idx);
        vector_entry = VECTOR_TABLE[idx];
    endfunction

    function automatic logic ctrl_hit(input logic [ADR_W-1:0] adr);
        ctrl_hit = (adr >= ADR_CTRL_BASE) && (adr <= ADR_CTRL_LAST);
    endfunction

    function automatic logic [IDX_W-1:0] ctrl_index(input logic [ADR_W-1:0] adr);
        logic [ADR_W-1:0] off;
        off = adr - ADR_CTRL_BASE;
        ctrl_index = IDX_W'(off >> ADR_WORD_SHIFT);
    endfunction

endpackage

// >>> design/request_capture.sv
// Request capture for one source group, edge or level detected
module request_capture import icu_pkg::*; #(
    parameter bit IS_EDGE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Source and controls
    input wire logic req_n,
    input wire logic sw_write,
    input wire logic sw_value,
    input wire logic vec_clear,
    // State
    output logic pending,
    output logic edge_seen
);

    logic prev_q;
    logic pend_q;
    logic fall;

    assign fall = IS_EDGE & prev_q & ~req_n;
    assign edge_seen = fall;
    assign pending = pend_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= req_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_q <= 1'b0;
        end else if (!IS_EDGE) begin
            pend_q <= ~req_n;
        end else if (vec_clear || (sw_write && !sw_value)) begin
            pend_q <= 1'b0;
        end else if (fall || (sw_write && sw_value)) begin
            pend_q <= 1'b1;
        end
    end

endmodule

// >>> design/priority_resolver.sv
// Combinational winner selection by level, then fixed order
module priority_resolver import icu_pkg::*; (
    // Candidates
    input wire logic [NUM_SRC-1:0] pending,
    input wire logic [LVL_W-1:0] level [NUM_SRC],
    // Winner
    output logic win_valid,
    output logic [IDX_W-1:0] win_idx,
    output logic [LVL_W-1:0] win_level
);

    always_comb begin
        win_valid = 1'b0;
        win_idx = IDX_RESET;
        win_level = LEVEL_DISABLED;
        // lowest level wins; scanning downward lets lower index win ties
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i] && level[i] != LEVEL_DISABLED && (!win_valid || level[i] <= win_level)) begin
                win_valid = 1'b1;
                win_idx = IDX_W'(i);
                win_level = level[i];
            end
        end
    end

endmodule

// >>> design/interrupt_control_unit.sv
// Interrupt control unit: capture, priority, mask compare and vector register

module interrupt_control_unit import icu_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // Peripheral request groups, active low
    input wire logic [NUM_SRC-1:0] src_req_n,
    // CPU side
    output logic cpu_interrupt_request,
    // Event interrupt
    output logic event_irq
);

    logic ack_q;
    logic [31:0] dat_q;
    logic bus_req;
    logic take;
    logic done;
    logic wr_done;
    logic mask_wr;
    logic vec_rd;
    logic ctrl_wr;
    logic [IDX_W-1:0] wr_idx;

    res_state_t state_q;
    logic [LVL_W-1:0] mask_q;
    logic [VEC_W-1:0] vec_q;
    logic [IDX_W-1:0] acc_idx_q;
    logic [LVL_W-1:0] acc_level_q;
    logic [LVL_W-1:0] level_q [NUM_SRC];
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] edge_seen;
    logic win_valid;
    logic [IDX_W-1:0] win_idx;
    logic [LVL_W-1:0] win_level;
    logic accept;
    logic vec_side;

    logic [EV_W-1:0] status_q;
    logic [EV_W-1:0] enable_q;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    // Bus strobes; effects land on the edge where the master sees ack
    assign bus_req = wb_cyc & wb_stb;
    assign take = bus_req & ~ack_q;
    assign done = bus_req & ack_q;
    assign wr_done = done & wb_we & wb_sel[0];
    assign mask_wr = wr_done && (wb_adr == ADR_MASK);
    assign vec_rd = done && !wb_we && (wb_adr == ADR_VECTOR);
    assign ctrl_wr = wr_done && ctrl_hit(wb_adr);
    assign wr_idx = ctrl_index(wb_adr);
    assign vec_side = vec_rd && (state_q == ST_REQUEST);

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    assign cpu_interrupt_request = (state_q == ST_REQUEST);
    assign event_irq = |(status_q & enable_q);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // Read data sampled at take; resolution is frozen until ack, so it matches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dat_q <= DATA_ZERO;
        end else if (take && !wb_we) begin
            if (ctrl_hit(wb_adr)) begin
                dat_q <= DATA_ZERO;
                dat_q[CTRL_LVL_LSB +: LVL_W] <= level_q[ctrl_index(wb_adr)];
                dat_q[CTRL_PEND_BIT] <= pending[ctrl_index(wb_adr)];
            end else begin
                unique case (wb_adr)
                    ADR_MASK: dat_q <= {29'h0000_0000, mask_q};
                    // low address bits of the accepted entry
                    ADR_VECTOR: dat_q <= {16'h0000, vec_q};
                    ADR_STATUS: dat_q <= {30'h0000_0000, status_q};
                    ADR_ENABLE: dat_q <= {30'h0000_0000, enable_q};
                    default: dat_q <= DATA_ZERO;
                endcase
            end
        end
    end

    // Level fields per source
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                level_q[i] <= LEVEL_RESET;
            end
        end else if (ctrl_wr) begin
            level_q[wr_idx] <= wb_dat_w[CTRL_LVL_LSB +: LVL_W];
        end
    end

    // one capture stage per group, kind fixed per group
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        request_capture #(
            .IS_EDGE(EDGE_SRC[g])
        ) u_cap (
            .ref_clk(ref_clk),
            .rst(rst),
            .req_n(src_req_n[g]),
            .sw_write(ctrl_wr && (wr_idx == IDX_W'(g))),
            .sw_value(wb_dat_w[CTRL_PEND_BIT]),
            .vec_clear(vec_side && (acc_idx_q == IDX_W'(g))),
            .pending(pending[g]),
            .edge_seen(edge_seen[g])
        );
    end

    priority_resolver u_res (
        .pending(pending),
        .level(level_q),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_level(win_level)
    );

    // accept only when the winner is below the mask
    assign accept = (state_q == ST_RESOLVE) && !bus_req && win_valid && (win_level < mask_q);

    // resolution repeats every idle cycle until something is accepted
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_RESOLVE;
        end else begin
            unique case (state_q)
                ST_RESOLVE: begin
                    if (accept) begin
                        state_q <= ST_REQUEST;
                    end
                end
                ST_REQUEST: begin
                    if (vec_rd || mask_wr) begin
                        state_q <= ST_RESOLVE;
                    end
                end
            endcase
        end
    end

    // vector latched from the table at acceptance
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vec_q <= VEC_RESET;
            acc_idx_q <= IDX_RESET;
            acc_level_q <= LEVEL_RESET;
        end else if (accept) begin
            vec_q <= vector_entry(win_idx);
            acc_idx_q <= win_idx;
            acc_level_q <= win_level;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q <= MASK_RESET;
        end else if (mask_wr) begin
            mask_q <= wb_dat_w[LVL_W-1:0];
        end else if (vec_side) begin
            // accepted level becomes the new mask
            mask_q <= acc_level_q;
        end
    end

    // Event status: sticky, set wins over a clear in the same cycle
    assign ev_set[EV_ACCEPT] = accept;
    assign ev_set[EV_EDGE] = |edge_seen;
    assign ev_clr = (wr_done && (wb_adr == ADR_CLEAR)) ? wb_dat_w[EV_W-1:0] : EV_RESET;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= EV_RESET;
        end else begin
            status_q <= (status_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_q <= EV_RESET;
        end else if (wr_done && (wb_adr == ADR_ENABLE)) begin
            enable_q <= wb_dat_w[EV_W-1:0];
        end
    end

    // Helper: a pending enabled candidate that should have beaten the winner
    logic better_exists;
    always_comb begin
        better_exists = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pending[i] && level_q[i] != LEVEL_DISABLED &&
                (level_q[i] < win_level || (level_q[i] == win_level && IDX_W'(i) < win_idx))) begin
                better_exists = 1'b1;
            end
        end
    end

    // Watched groups for the capture checks: timer output 5 is edge, timer input 4 is level
    localparam logic [IDX_W-1:0] WATCH_EDGE_IDX = 5'h06;
    localparam logic [IDX_W-1:0] WATCH_LEVEL_IDX = 5'h00;
    logic watch_clr;
    assign watch_clr = (vec_side && acc_idx_q == WATCH_EDGE_IDX)
        || (ctrl_wr && wr_idx == WATCH_EDGE_IDX && !wb_dat_w[CTRL_PEND_BIT]);

    property p_winner_best;
        @(posedge ref_clk) disable iff (rst)
        win_valid |-> !better_exists;
    endproperty
    a_winner_best: assert property (p_winner_best)
        else $error("winner is not the best pending candidate");

    property p_vector_table;
        @(posedge ref_clk) disable iff (rst)
        accept |=> cpu_interrupt_request && vec_q == vector_entry($past(win_idx));
    endproperty
    a_vector_table: assert property (p_vector_table)
        else $error("vector not loaded from table at acceptance");

    property p_mask_compare;
        @(posedge ref_clk) disable iff (rst)
        $rose(cpu_interrupt_request) |-> acc_level_q < $past(mask_q);
    endproperty
    a_mask_compare: assert property (p_mask_compare)
        else $error("request raised for level not below mask");

    property p_never_disabled;
        @(posedge ref_clk) disable iff (rst)
        cpu_interrupt_request |-> acc_level_q != LEVEL_DISABLED;
    endproperty
    a_never_disabled: assert property (p_never_disabled)
        else $error("disabled level accepted");

    property p_request_holds;
        @(posedge ref_clk) disable iff (rst)
        cpu_interrupt_request && !vec_rd && !mask_wr |=> cpu_interrupt_request;
    endproperty
    a_request_holds: assert property (p_request_holds)
        else $error("cpu request dropped without vector read or mask write");

    property p_vector_read;
        @(posedge ref_clk) disable iff (rst)
        vec_side |=> !cpu_interrupt_request && mask_q == $past(acc_level_q)
            && (!EDGE_SRC[$past(acc_idx_q)] || !pending[$past(acc_idx_q)]);
    endproperty
    a_vector_read: assert property (p_vector_read)
        else $error("vector read side effects missing");

    property p_mask_write;
        @(posedge ref_clk) disable iff (rst)
        mask_wr |=> !cpu_interrupt_request && mask_q == $past(wb_dat_w[LVL_W-1:0])
            ##1 cpu_interrupt_request == $past(accept);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write did not drop and restart");

    property p_level_follow;
        @(posedge ref_clk) disable iff (rst)
        !src_req_n[0] ##1 !src_req_n[0] |-> pending[0];
    endproperty
    a_level_follow: assert property (p_level_follow)
        else $error("level source not pending while held low");

    property p_retry;
        @(posedge ref_clk) disable iff (rst)
        pending[WATCH_EDGE_IDX] && !watch_clr |=> pending[WATCH_EDGE_IDX];
    endproperty
    a_retry: assert property (p_retry)
        else $error("edge request lost before acceptance or clear");

    property p_ack_pulse;
        @(posedge ref_clk) disable iff (rst)
        wb_ack |=> !wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    property p_edge_capture;
        @(posedge ref_clk) disable iff (rst)
        !src_req_n[WATCH_EDGE_IDX] && $past(src_req_n[WATCH_EDGE_IDX]) && !watch_clr |=> pending[WATCH_EDGE_IDX];
    endproperty
    a_edge_capture: assert property (p_edge_capture)
        else $error("falling edge not captured");

    property p_level_only;
        @(posedge ref_clk) disable iff (rst)
        src_req_n[WATCH_LEVEL_IDX] |=> !pending[WATCH_LEVEL_IDX];
    endproperty
    a_level_only: assert property (p_level_only)
        else $error("level source pending while input high");

    property p_vector_idle;
        @(posedge ref_clk) disable iff (rst)
        vec_rd && !cpu_interrupt_request |=> $stable(mask_q) && !cpu_interrupt_request;
    endproperty
    a_vector_idle: assert property (p_vector_idle)
        else $error("idle vector read had side effects");

    property p_read_vector;
        @(posedge ref_clk) disable iff (rst)
        take && !wb_we && wb_adr == ADR_VECTOR |=> wb_dat_r[VEC_W-1:0] == $past(vec_q);
    endproperty
    a_read_vector: assert property (p_read_vector)
        else $error("vector read data differs from latched vector");

    property p_freeze;
        @(posedge ref_clk) disable iff (rst)
        bus_req && !cpu_interrupt_request |=> !cpu_interrupt_request;
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("request accepted during a bus access");

endmodule

// >>> bench/cpu_model.sv
// Behavioural CPU core that takes the external interrupt request
module cpu_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request and the core's own enable flag
    input wire logic cpu_interrupt_request,
    input wire logic cpu_interrupt_enable,
    // Requests taken by the core
    output logic [7:0] taken_count
);
    timeunit 1ns;
    timeprecision 1ps;

    logic req_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_q <= 1'b0;
            taken_count <= 8'h00;
        end else begin
            req_q <= cpu_interrupt_request;
            // A request rising while the flag is clear is missed, as on the real core
            if (cpu_interrupt_request && !req_q && cpu_interrupt_enable) begin
                taken_count <= taken_count + 8'h01;
            end
        end
    end
endmodule

// >>> bench/testbench.sv
// Self-checking bench: register tasks and interrupt scenarios
module testbench import icu_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [NUM_SRC-1:0] src_req_n = 23'h7FFFFF;
    logic cpu_interrupt_request;
    logic event_irq;
    logic cpu_interrupt_enable = 1'b0;
    logic [7:0] taken_count;
    logic [7:0] taken_base;
    logic [31:0] rd;
    logic got;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] vec_exp [23] = '{16'h0094, 16'h0098, 16'h009C, 16'h00A0, 16'h00A8, 16'h00AC, 16'h00B0,
        16'h00B4, 16'h00B8, 16'h00BC, 16'h00C0, 16'h00C4, 16'h00C8, 16'h00CC, 16'h00D0, 16'h00D4,
        16'h00D8, 16'h00DC, 16'h00E8, 16'h00EC, 16'h00F0, 16'h010C, 16'h0110};

    interrupt_control_unit u_interrupt_control_unit (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .src_req_n(src_req_n),
        .cpu_interrupt_request(cpu_interrupt_request), .event_irq(event_irq));
    cpu_model u_cpu_model (.ref_clk(ref_clk), .rst(rst), .cpu_interrupt_request(cpu_interrupt_request),
        .cpu_interrupt_enable(cpu_interrupt_enable), .taken_count(taken_count));

    always #2 ref_clk = ~ref_clk;

    // Hang guard, far above the thousand or so cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            $display("Error at %0t: timeout", $time);
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string what);
        comparisons++;
        if (got_v !== exp_v) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
        end
    endtask

    // Core keeps its enable flag clear for the whole access
    task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge ref_clk);
        cpu_interrupt_enable <= 1'b0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1);
        chk(32'(n), 32'h2, "ack latency");
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        cpu_interrupt_enable <= 1'b1;
    endtask

    task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask

    task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [31:0] exp_v, input string what);
        wb_xfer(1'b0, adr, 32'h0);
        chk(rd, exp_v, what);
    endtask

    task automatic setlvl(input int i, input logic [2:0] l);
        wr(ADR_CTRL_BASE + ADR_W'(4 * i), {29'h0, l});
    endtask

    task automatic src(input int i, input logic v);
        @(posedge ref_clk);
        src_req_n[i] <= v;
    endtask

    task automatic wait_req(input int n);
        got = 1'b0;
        for (int k = 0; k < n && got !== 1'b1; k++) begin
            @(posedge ref_clk);
            if (cpu_interrupt_request === 1'b1) got = 1'b1;
        end
    endtask

    task automatic expect_drop();
        @(posedge ref_clk);
        chk({31'h0, cpu_interrupt_request}, 32'h0, "request drop");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(ADR_MASK, 32'h7, "mask reset");
        rd_chk(ADR_CTRL_BASE, 32'h7, "control reset");
        rd_chk(ADR_VECTOR, 32'h0, "vector reset");
        wr(8'h20, 32'hFF);
        rd_chk(8'h20, 32'h0, "unmapped read");
        $display("test reset done");

        taken_base = taken_count;
        for (int i = 0; i < NUM_SRC; i++) begin
            setlvl(i, 3'h0);
            src(i, 1'b0);
            wait_req(10);
            chk({31'h0, got}, 32'h1, "request raised");
            rd_chk(ADR_VECTOR, {16'h0, vec_exp[i]}, "vector entry");
            expect_drop();
            rd_chk(ADR_MASK, 32'h0, "mask loaded");
            src(i, 1'b1);
            setlvl(i, 3'h7);
            wr(ADR_MASK, 32'h7);
        end
        chk({24'h0, taken_count - taken_base}, 32'h17, "requests taken");
        $display("test vector table done");

        setlvl(0, 3'h5);
        setlvl(22, 3'h2);
        @(posedge ref_clk);
        src_req_n <= ~23'h400001;
        wait_req(10);
        rd_chk(ADR_VECTOR, 32'h0110, "level beats order");
        src_req_n <= ~23'h000001;
        setlvl(22, 3'h7);
        wr(ADR_MASK, 32'h7);
        wait_req(10);
        rd_chk(ADR_VECTOR, 32'h0094, "loser retried");
        src_req_n <= 23'h7FFFFF;
        wr(ADR_MASK, 32'h7);
        setlvl(1, 3'h4);
        setlvl(3, 3'h4);
        @(posedge ref_clk);
        src_req_n <= ~23'h00000A;
        wait_req(10);
        rd_chk(ADR_VECTOR, 32'h0098, "tie by order");
        src_req_n <= 23'h7FFFFF;
        setlvl(0, 3'h7);
        setlvl(1, 3'h7);
        setlvl(3, 3'h7);
        wr(ADR_MASK, 32'h7);
        $display("test priority done");

        src(5, 1'b0);
        for (int l = 0; l < 7; l++) begin
            wr(ADR_MASK, 32'(l));
            setlvl(5, 3'(l));
            wait_req(8);
            chk({31'h0, got}, 32'h0, "mask equal level");
            wr(ADR_MASK, 32'(l + 1));
            wait_req(8);
            chk({31'h0, got}, 32'h1, "mask above level");
            wr(ADR_MASK, 32'(l + 1));
            expect_drop();
            wait_req(8);
            chk({31'h0, got}, 32'h1, "request back");
            rd_chk(ADR_VECTOR, 32'h00AC, "masked source vector");
            expect_drop();
            // Disable first, else the next mask write accepts the old level at once
            setlvl(5, 3'h7);
        end
        wr(ADR_MASK, 32'h7);
        wait_req(8);
        chk({31'h0, got}, 32'h0, "level seven");
        src(5, 1'b1);
        $display("test mask done");

        setlvl(6, 3'h0);
        src(6, 1'b0);
        wait_req(10);
        rd_chk(ADR_VECTOR, 32'h00B0, "edge vector");
        rd_chk(ADR_CTRL_BASE + 8'h18, 32'h0, "edge cleared");
        wr(ADR_MASK, 32'h7);
        wait_req(8);
        chk({31'h0, got}, 32'h0, "held low no edge");
        src(6, 1'b1);
        src(6, 1'b0);
        wait_req(10);
        chk({31'h0, got}, 32'h1, "new falling edge");
        rd_chk(ADR_VECTOR, 32'h00B0, "edge vector again");
        src(6, 1'b1);
        setlvl(6, 3'h7);
        wr(ADR_MASK, 32'h7);
        wr(ADR_CTRL_BASE + 8'h18, 32'h17);
        rd_chk(ADR_CTRL_BASE + 8'h18, 32'h17, "edge soft set");
        wr(ADR_CTRL_BASE + 8'h18, 32'h07);
        rd_chk(ADR_CTRL_BASE + 8'h18, 32'h07, "edge soft clear");
        wr(ADR_CTRL_BASE, 32'h17);
        rd_chk(ADR_CTRL_BASE, 32'h07, "level soft set ignored");
        $display("test edge done");

        wr(ADR_ENABLE, 32'h0);
        @(posedge ref_clk);
        chk({31'h0, event_irq}, 32'h0, "event masked");
        rd_chk(ADR_STATUS, 32'h3, "event status");
        wr(ADR_ENABLE, 32'h3);
        rd_chk(ADR_ENABLE, 32'h3, "event enable");
        chk({31'h0, event_irq}, 32'h1, "event raised");
        wr(ADR_CLEAR, 32'h3);
        @(posedge ref_clk);
        chk({31'h0, event_irq}, 32'h0, "event cleared");
        rd_chk(ADR_STATUS, 32'h0, "status cleared");
        $display("test events done");
        results();
    end
endmodule
